// ### core/cfgaux_pkg.sv
/*
  Constants for the auxiliary configuration register group: offsets,
  field positions, reset values and access masks.
  Assumes an 8-bit register offset and 32-bit data words.
*/
package cfgaux_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] CFG_OFS_LINK_FEAT = 8'hf4;
  localparam logic [7:0] CFG_OFS_SUBSYS_ALIAS = 8'hf8;
  localparam logic [7:0] CFG_OFS_AUX_PIN_CTRL = 8'hfc;
  localparam logic [7:0] MEM_OFS_EVT_SET = 8'h80;
  localparam logic [7:0] MEM_OFS_EVT_CLR = 8'h84;
  localparam logic [7:0] MEM_OFS_MASK_SET = 8'h88;
  localparam logic [7:0] MEM_OFS_MASK_CLR = 8'h8c;

  // ==========================================================
  // Field positions
  localparam int LF_ACCEL_BIT = 1;
  localparam int LF_PHYPROG_BIT = 6;
  localparam int ALIAS_DEV_LSB = 16;
  localparam int PIN_NUM = 2;
  // Index 0 is aux_pin_a, index 1 is aux_pin_b
  localparam int PIN_LANE [PIN_NUM] = '{2, 3};
  localparam int PIN_IRQ_BIT [PIN_NUM] = '{23, 31};
  localparam int PIN_INV_BIT [PIN_NUM] = '{21, 29};
  localparam int PIN_DRV_BIT [PIN_NUM] = '{20, 28};
  localparam int PIN_VAL_BIT [PIN_NUM] = '{16, 24};
  localparam int GP_EVT_BIT = 25;
  localparam int GP_EVT_LANE = 3;

  // ==========================================================
  // Reset values and masks
  localparam logic LF_ACCEL_RST = 1'b0;
  localparam logic PHYPROG_RST = 1'b0;
  localparam logic [31:0] ALIAS_RST = 32'h0000_0000;
  localparam logic [PIN_NUM-1:0] PIN_FIELD_RST = 2'h0;
  localparam logic EVT_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [31:0] LF_RD_MASK = 32'h0000_0002;
  localparam logic [31:0] PIN_RD_MASK = 32'hb1b1_0000;
  localparam logic [3:0] BE_ALL = 4'hf;

endpackage

// ### core/cfgaux_pin.sv
/*
  One auxiliary pin input path: two-flop synchroniser, polarity
  invert of the read level and change detection.
  Assumes pin_in is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module cfgaux_pin
  import cfgaux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic invert,
  input wire logic irq_en,
  output logic level,
  output logic change
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic edge_seen;

  // ==========================================================
  // Synchroniser and change detect
  // sync then detect
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      change <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      change <= irq_en & edge_seen;
    end
  end

  // Raw level edges only: flipping invert is not a pin change
  assign edge_seen = sync2_r ^ prev_r;
  assign level = sync2_r ^ invert;

  // ==========================================================
  // Checks
  chg_one_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    change |=> !change || $changed(prev_r))
    else $error("pin change pulse without a new edge");
  chg_needs_en_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    change |-> $past(irq_en) && $past(sync2_r) != $past(prev_r))
    else $error("pin change raised without enable or edge");

endmodule // cfgaux_pin

// ### core/cfgaux_evt.sv
/*
  General-purpose event flag with its mask and interrupt output.
  Assumes single-cycle write strobes already gated by the data bit.
*/
`timescale 1ns/1ps
module cfgaux_evt
  import cfgaux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic evt_in,
  input wire logic evt_set_wr,
  input wire logic evt_clr_wr,
  input wire logic mask_set_wr,
  input wire logic mask_clr_wr,
  output logic evt_r,
  output logic mask_r,
  output logic irq_r
);

  logic evt_nxt;
  logic mask_nxt;

  // ==========================================================
  // Event and mask
  // event then mask
  // Hardware set beats a same-cycle software clear
  assign evt_nxt = evt_in | evt_set_wr | (evt_r & ~evt_clr_wr);
  assign mask_nxt = mask_set_wr | (mask_r & ~mask_clr_wr);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      evt_r <= EVT_RST;
      mask_r <= MASK_RST;
      irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      mask_r <= mask_nxt;
      irq_r <= evt_nxt & mask_nxt;
    end
  end

  // ==========================================================
  // Checks
  evt_set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt_in |=> evt_r)
    else $error("event lost against clear");
  irq_gated_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_r == (evt_r && mask_r))
    else $error("interrupt not equal to event and mask");

endmodule // cfgaux_evt

// ### core/cfgaux_regs.sv
/*
  Auxiliary configuration register group: link feature control,
  subsystem identification alias and auxiliary pin control, plus the
  general-purpose event and mask reached in memory space.
  Assumes a simple access port: one-cycle rd/wr strobes, byte enables,
  cfg_space low for configuration space and high for memory space.
*/
// Behaviour
// - Accel bit set tells the PHY that acceleration is supported.
// - Bit 6 reads zero; the loaded value drives phy_program_allow.
// - Link feature bits 5 to 2 read as zero.
// - Link feature bit 0 reads as zero.
// - Writing the alias register updates the subsystem identifiers.
// - Alias reads return last written value; resets to zero.
// - Alias upper half holds board device identifier, read/write.
// - Alias lower half holds board maker identifier, read/write.
// - Pin b change with its enable set raises an event.
// - Pin event is latched, then masked, before the interrupt.
// - Pin control bit 30 reads as zero.
// - Pin b invert bit flips pin b polarity.
// - Pin b drive enable drives the pin, else high impedance.
// - Pin control bits 27 to 25 read as zero.
// - Pin b value reads the live input level.
// - Pin b value write sets the level driven when enabled.
// - Pin a has the same four controls in bits 23,21,20,16.
// - Pin control bits 15-0, 22 and 19-17 read as zero.
`timescale 1ns/1ps
module cfgaux_regs
  import cfgaux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfg_space,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata_r,
  output logic cfg_ack_r,
  input wire logic eeprom_load,
  input wire logic [7:0] eeprom_enh,
  output logic phy_accel_support_r,
  output logic phy_program_allow_r,
  output logic [15:0] board_device_alias_r,
  output logic [15:0] board_maker_alias_r,
  input wire logic [PIN_NUM-1:0] aux_pin_in,
  output logic [PIN_NUM-1:0] aux_pin_out_r,
  output logic [PIN_NUM-1:0] aux_pin_oe_r,
  output logic irq_r
);

  // ==========================================================
  // Address decode
  logic sel_cfg;
  logic sel_mem;
  logic hit_lf;
  logic hit_ss;
  logic hit_pin;
  logic hit_evs;
  logic hit_evc;
  logic hit_mks;
  logic hit_mkc;
  logic wr_lf;
  logic wr_ss;
  logic wr_pin;

  assign sel_cfg = ~cfg_space;
  assign sel_mem = cfg_space;
  assign hit_lf = sel_cfg && (cfg_addr == CFG_OFS_LINK_FEAT);
  assign hit_ss = sel_cfg && (cfg_addr == CFG_OFS_SUBSYS_ALIAS);
  assign hit_pin = sel_cfg && (cfg_addr == CFG_OFS_AUX_PIN_CTRL);
  assign hit_evs = sel_mem && (cfg_addr == MEM_OFS_EVT_SET);
  assign hit_evc = sel_mem && (cfg_addr == MEM_OFS_EVT_CLR);
  assign hit_mks = sel_mem && (cfg_addr == MEM_OFS_MASK_SET);
  assign hit_mkc = sel_mem && (cfg_addr == MEM_OFS_MASK_CLR);
  assign wr_lf = cfg_wr && hit_lf;
  assign wr_ss = cfg_wr && hit_ss;
  assign wr_pin = cfg_wr && hit_pin;

  // ==========================================================
  // Link feature control
  logic accel_nxt;
  logic phyprog_nxt;

  assign accel_nxt = (wr_lf && cfg_be[0]) ? cfg_wdata[LF_ACCEL_BIT]
                                          : phy_accel_support_r;
  assign phyprog_nxt = eeprom_load ? eeprom_enh[LF_PHYPROG_BIT]
                                   : phy_program_allow_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phy_accel_support_r <= LF_ACCEL_RST;
      phy_program_allow_r <= PHYPROG_RST;
    end else begin
      phy_accel_support_r <= accel_nxt;
      phy_program_allow_r <= phyprog_nxt;
    end
  end

  // ==========================================================
  // Subsystem identification alias
  logic [31:0] alias_word;
  logic [31:0] alias_nxt;

  // device half high, maker half low
  assign alias_word = {board_device_alias_r, board_maker_alias_r};

  for (genvar b = 0; b < 4; b++) begin : g_alias
    assign alias_nxt[8*b +: 8] = (wr_ss && cfg_be[b])
                                 ? cfg_wdata[8*b +: 8]
                                 : alias_word[8*b +: 8];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      board_device_alias_r <= ALIAS_RST[31:ALIAS_DEV_LSB];
      board_maker_alias_r <= ALIAS_RST[ALIAS_DEV_LSB-1:0];
    end else begin
      board_device_alias_r <= alias_nxt[31:ALIAS_DEV_LSB];
      board_maker_alias_r <= alias_nxt[ALIAS_DEV_LSB-1:0];
    end
  end

  // ==========================================================
  // Auxiliary pin control
  logic [PIN_NUM-1:0] wr_lane;
  logic [PIN_NUM-1:0] irq_en_r;
  logic [PIN_NUM-1:0] irq_en_nxt;
  logic [PIN_NUM-1:0] inv_r;
  logic [PIN_NUM-1:0] inv_nxt;
  logic [PIN_NUM-1:0] drv_r;
  logic [PIN_NUM-1:0] drv_nxt;
  logic [PIN_NUM-1:0] dout_r;
  logic [PIN_NUM-1:0] dout_nxt;
  logic [PIN_NUM-1:0] pin_level;
  logic [PIN_NUM-1:0] pin_change;
  logic [31:0] pin_part [PIN_NUM];
  logic [31:0] pin_word;

  for (genvar g = 0; g < PIN_NUM; g++) begin : g_pin
    assign wr_lane[g] = wr_pin && cfg_be[PIN_LANE[g]];
    assign irq_en_nxt[g] = wr_lane[g] ? cfg_wdata[PIN_IRQ_BIT[g]]
                                      : irq_en_r[g];
    assign inv_nxt[g] = wr_lane[g] ? cfg_wdata[PIN_INV_BIT[g]]
                                   : inv_r[g];
    assign drv_nxt[g] = wr_lane[g] ? cfg_wdata[PIN_DRV_BIT[g]]
                                   : drv_r[g];
    assign dout_nxt[g] = wr_lane[g] ? cfg_wdata[PIN_VAL_BIT[g]]
                                    : dout_r[g];

    cfgaux_pin u_pin (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(aux_pin_in[g]),
      .invert(inv_r[g]),
      .irq_en(irq_en_r[g]),
      .level(pin_level[g]),
      .change(pin_change[g])
    );

    assign pin_part[g] = (32'(irq_en_r[g]) << PIN_IRQ_BIT[g])
                       | (32'(inv_r[g]) << PIN_INV_BIT[g])
                       | (32'(drv_r[g]) << PIN_DRV_BIT[g])
                       | (32'(pin_level[g]) << PIN_VAL_BIT[g]);
  end

  // the same: only pin fields are placed
  assign pin_word = pin_part[0] | pin_part[1];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_en_r <= PIN_FIELD_RST;
      inv_r <= PIN_FIELD_RST;
      drv_r <= PIN_FIELD_RST;
      dout_r <= PIN_FIELD_RST;
      aux_pin_out_r <= PIN_FIELD_RST;
      aux_pin_oe_r <= PIN_FIELD_RST;
    end else begin
      irq_en_r <= irq_en_nxt;
      inv_r <= inv_nxt;
      drv_r <= drv_nxt;
      dout_r <= dout_nxt;
      aux_pin_out_r <= dout_nxt ^ inv_nxt;
      aux_pin_oe_r <= drv_nxt;
    end
  end

  // ==========================================================
  // General-purpose event and mask
  logic gp_evt;
  logic evt_bit_wr;
  logic evt_flag;
  logic mask_flag;

  assign gp_evt = |pin_change;
  assign evt_bit_wr = cfg_wr && cfg_be[GP_EVT_LANE]
                      && cfg_wdata[GP_EVT_BIT];

  cfgaux_evt u_evt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .evt_in(gp_evt),
    .evt_set_wr(evt_bit_wr && hit_evs),
    .evt_clr_wr(evt_bit_wr && hit_evc),
    .mask_set_wr(evt_bit_wr && hit_mks),
    .mask_clr_wr(evt_bit_wr && hit_mkc),
    .evt_r(evt_flag),
    .mask_r(mask_flag),
    .irq_r(irq_r)
  );

  // ==========================================================
  // Read mux and answer
  logic [31:0] lf_word;
  logic [31:0] evt_word;
  logic [31:0] evt_masked_word;
  logic [31:0] mask_word;
  logic [31:0] rd_word;

  // bit 0 zero too, and bit 6 is not returned
  assign lf_word = 32'(phy_accel_support_r) << LF_ACCEL_BIT;
  assign evt_word = 32'(evt_flag) << GP_EVT_BIT;
  assign evt_masked_word = 32'(evt_flag & mask_flag) << GP_EVT_BIT;
  assign mask_word = 32'(mask_flag) << GP_EVT_BIT;

  // Unmapped offsets answer with zero data rather than stalling
  assign rd_word = hit_lf ? lf_word
                 : hit_ss ? alias_word
                 : hit_pin ? pin_word
                 : hit_evs ? evt_word
                 : hit_evc ? evt_masked_word
                 : (hit_mks || hit_mkc) ? mask_word
                 : RD_UNMAPPED;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_rdata_r <= RD_UNMAPPED;
      cfg_ack_r <= 1'b0;
    end else begin
      cfg_rdata_r <= cfg_rd ? rd_word : RD_UNMAPPED;
      cfg_ack_r <= cfg_rd || cfg_wr;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence lf_acc_wr_s;
    wr_lf && cfg_be[0];
  endsequence

  sequence alias_full_wr_s;
    wr_ss && cfg_be == BE_ALL;
  endsequence

  sequence alias_rd_s;
    cfg_rd && hit_ss && !cfg_wr;
  endsequence

  sequence pin_rd_s;
    cfg_rd && hit_pin;
  endsequence

  accel_out_a: assert property (
    lf_acc_wr_s |=> phy_accel_support_r == $past(cfg_wdata[LF_ACCEL_BIT]))
    else $error("accel support output does not follow write");

  phyprog_load_a: assert property (
    eeprom_load |=> phy_program_allow_r == $past(eeprom_enh[LF_PHYPROG_BIT]))
    else $error("program allow not loaded from eeprom byte");

  lf_rsvd_zero_a: assert property (
    cfg_rd && hit_lf |=> (cfg_rdata_r & ~LF_RD_MASK) == RD_UNMAPPED)
    else $error("link feature reserved bits not zero");

  lf_accel_rd_a: assert property (
    cfg_rd && hit_lf
    |=> cfg_rdata_r[LF_ACCEL_BIT] == $past(phy_accel_support_r))
    else $error("link feature accel bit read mismatch");

  alias_write_a: assert property (
    alias_full_wr_s |=> alias_word == $past(cfg_wdata))
    else $error("alias write did not update identifiers");

  alias_read_a: assert property (
    alias_full_wr_s ##1 !wr_ss ##1 alias_rd_s
    |=> cfg_rdata_r == $past(cfg_wdata, 3))
    else $error("alias read does not return last write");

  alias_hi_a: assert property (
    wr_ss && cfg_be[3:2] == 2'h3 && !cfg_be[0]
    |=> board_device_alias_r == $past(cfg_wdata[31:ALIAS_DEV_LSB])
        && $stable(board_maker_alias_r[7:0]))
    else $error("device alias half not written alone");

  alias_lo_a: assert property (
    wr_ss && cfg_be[1:0] == 2'h3 && !cfg_be[3]
    |=> board_maker_alias_r == $past(cfg_wdata[ALIAS_DEV_LSB-1:0])
        && $stable(board_device_alias_r[15:8]))
    else $error("maker alias half not written alone");

  pin_rsvd_a: assert property (
    pin_rd_s |=> (cfg_rdata_r & ~PIN_RD_MASK) == RD_UNMAPPED)
    else $error("pin control reserved bits not zero");

  pin_oe_a: assert property (
    wr_lane[1] |=> aux_pin_oe_r[1] == $past(cfg_wdata[PIN_DRV_BIT[1]]))
    else $error("pin b drive enable not applied");

  pin_out_a: assert property (
    wr_lane[1] |=> aux_pin_out_r[1] == ($past(cfg_wdata[PIN_VAL_BIT[1]])
                   ^ $past(cfg_wdata[PIN_INV_BIT[1]])))
    else $error("pin b driven level wrong");

  pin_value_a: assert property (
    pin_rd_s |=> cfg_rdata_r[PIN_VAL_BIT[1]] == $past(pin_level[1])
                 && cfg_rdata_r[PIN_VAL_BIT[0]] == $past(pin_level[0]))
    else $error("pin value bit not the input level");

  pin_irq_path_a: assert property (
    pin_change[1] && mask_flag && !hit_mkc |=> irq_r)
    else $error("pin b change did not reach interrupt");

  ack_timing_a: assert property (
    (cfg_rd || cfg_wr) |=> cfg_ack_r ##1 !cfg_ack_r || $past(cfg_rd || cfg_wr))
    else $error("access answer not one cycle");

endmodule // cfgaux_regs

// ### tb/cfgaux_pin_mdl.sv
/*
  Far-side model of the two auxiliary pins: resolves the wire level from
  the block's drive and an external driver set by the bench.
  Where the bench and the block both drive a pin, the block's drive wins.
*/
`timescale 1ns/1ps
module cfgaux_pin_mdl (
  input wire logic clk_sys,
  input wire logic [1:0] oe,
  input wire logic [1:0] drv,
  input wire logic [1:0] ext_en,
  input wire logic [1:0] ext_val,
  output logic [1:0] pin
);
  // ==========================================================
  // Floating level
  // No pull on these pins, so an undriven pin wanders every cycle
  logic [1:0] float_r = 2'b01;
  always @(posedge clk_sys) begin
    float_r <= ~float_r;
  end

  // ==========================================================
  // Wire resolution
  // drive or high impedance
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = oe[i] ? drv[i] : (ext_en[i] ? ext_val[i] : float_r[i]);
    end
  end
endmodule // cfgaux_pin_mdl

// ### tb/cfgaux_regs_tb.sv
/*
  Self-checking bench for the auxiliary register group: register
  accesses, eeprom load, pin drive and read-back, event and mask.
  Assumes the one-cycle strobe port and one-cycle acknowledge.
*/
`timescale 1ns/1ps
module cfgaux_regs_tb;
  import cfgaux_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_space = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata_r;
  logic cfg_ack_r;
  logic eeprom_load = 1'b0;
  logic [7:0] eeprom_enh = 8'h00;
  logic phy_accel_support_r;
  logic phy_program_allow_r;
  logic [15:0] board_device_alias_r;
  logic [15:0] board_maker_alias_r;
  logic [1:0] pin_w;
  logic [1:0] aux_pin_out_r;
  logic [1:0] aux_pin_oe_r;
  logic irq_r;
  logic [1:0] ext_val = 2'b00;
  logic [31:0] seed = 32'h9424d635;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int checks = 0;

  always #20 clk_sys = ~clk_sys;

  cfgaux_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .cfg_space(cfg_space), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata_r(cfg_rdata_r), .cfg_ack_r(cfg_ack_r),
    .eeprom_load(eeprom_load), .eeprom_enh(eeprom_enh),
    .phy_accel_support_r(phy_accel_support_r),
    .phy_program_allow_r(phy_program_allow_r),
    .board_device_alias_r(board_device_alias_r),
    .board_maker_alias_r(board_maker_alias_r), .aux_pin_in(pin_w),
    .aux_pin_out_r(aux_pin_out_r), .aux_pin_oe_r(aux_pin_oe_r),
    .irq_r(irq_r));

  cfgaux_pin_mdl pin_u (.clk_sys(clk_sys), .oe(aux_pin_oe_r),
    .drv(aux_pin_out_r), .ext_en(2'b11), .ext_val(ext_val), .pin(pin_w));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic sp, input logic [7:0] a, input logic w,
                     input logic [3:0] b, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk_sys);
    #1;
    cfg_space = sp;
    cfg_addr = a;
    cfg_wr = w;
    cfg_rd = ~w;
    cfg_be = b;
    cfg_wdata = d;
    exp_q.push_back(w ? 32'h0 : e);
    @(posedge clk_sys);
    #1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  endtask

  task automatic wr32(input logic sp, input logic [7:0] a,
                      input logic [3:0] b, input logic [31:0] d);
    acc(sp, a, 1'b1, b, d, 32'h0);
  endtask

  task automatic rd32(input logic sp, input logic [7:0] a,
                      input logic [31:0] e);
    acc(sp, a, 1'b0, 4'h0, 32'h0, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_irq(input logic e);
    int n;
    for (n = 0; n < 10; n++) begin
      @(negedge clk_sys);
      if (irq_r === e) break;
    end
    chk({31'h0, irq_r}, {31'h0, e});
    if (n == 10) summarize();
  endtask

  task automatic load_enh(input logic [7:0] v);
    @(posedge clk_sys);
    #1;
    eeprom_enh = v;
    eeprom_load = 1'b1;
    settle(1);
    eeprom_load = 1'b0;
    settle(1);
  endtask

  task automatic summarize();
    if (exp_q.size() != 0) bad_count++;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Read-data monitor
  // Every acknowledge consumes one note; idle cycles must read zero
  always @(negedge clk_sys) begin
    if (rst_n === 1'b1 && cfg_ack_r === 1'b1) begin
      if (exp_q.size() == 0) chk(~cfg_rdata_r, cfg_rdata_r);
      else chk(cfg_rdata_r, exp_q.pop_front());
    end else if (rst_n === 1'b1 && cfg_rdata_r !== 32'h0) begin
      chk(cfg_rdata_r, 32'h0);
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd32(1'b0, CFG_OFS_LINK_FEAT, 32'h0);
    rd32(1'b0, CFG_OFS_SUBSYS_ALIAS, ALIAS_RST);
    rd32(1'b0, CFG_OFS_AUX_PIN_CTRL, 32'h0);
    rd32(1'b1, MEM_OFS_EVT_SET, 32'h0);
    $display("test reset done");

    wr32(1'b0, CFG_OFS_LINK_FEAT, BE_ALL, 32'hffff_ffff);
    chk({31'h0, phy_accel_support_r}, 32'h1);
    rd32(1'b0, CFG_OFS_LINK_FEAT, LF_RD_MASK);
    load_enh(8'h40);
    chk({31'h0, phy_program_allow_r}, 32'h1);
    rd32(1'b0, CFG_OFS_LINK_FEAT, LF_RD_MASK);
    load_enh(8'hbf);
    chk({31'h0, phy_program_allow_r}, 32'h0);
    wr32(1'b0, CFG_OFS_LINK_FEAT, BE_ALL, 32'h0);
    chk({31'h0, phy_accel_support_r}, 32'h0);
    $display("test link done");

    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr32(1'b0, CFG_OFS_SUBSYS_ALIAS, BE_ALL, seed);
      chk({16'h0, board_device_alias_r}, {16'h0, seed[31:16]});
      chk({16'h0, board_maker_alias_r}, {16'h0, seed[15:0]});
      rd32(1'b0, CFG_OFS_SUBSYS_ALIAS, seed);
    end
    wr32(1'b0, CFG_OFS_SUBSYS_ALIAS, 4'h3, ~seed);
    rd32(1'b0, CFG_OFS_SUBSYS_ALIAS, {seed[31:16], ~seed[15:0]});
    wr32(1'b0, CFG_OFS_SUBSYS_ALIAS, 4'hc, ~seed);
    chk({16'h0, board_device_alias_r}, {16'h0, ~seed[31:16]});
    wr32(1'b0, 8'h40, BE_ALL, 32'hffff_ffff);
    rd32(1'b0, 8'h40, RD_UNMAPPED);
    rd32(1'b0, CFG_OFS_SUBSYS_ALIAS, ~seed);
    $display("test alias done");

    wr32(1'b0, CFG_OFS_AUX_PIN_CTRL, BE_ALL, 32'hffff_ffff);
    chk({30'h0, aux_pin_oe_r}, 32'h3);
    chk({30'h0, aux_pin_out_r}, 32'h0);
    settle(4);
    rd32(1'b0, CFG_OFS_AUX_PIN_CTRL, PIN_RD_MASK);
    wr32(1'b0, CFG_OFS_AUX_PIN_CTRL, BE_ALL, 32'h1111_0000);
    chk({30'h0, aux_pin_out_r}, 32'h3);
    settle(4);
    rd32(1'b0, CFG_OFS_AUX_PIN_CTRL, 32'h1111_0000);
    ext_val = 2'b10;
    wr32(1'b0, CFG_OFS_AUX_PIN_CTRL, BE_ALL, 32'h0);
    chk({30'h0, aux_pin_oe_r}, 32'h0);
    settle(4);
    rd32(1'b0, CFG_OFS_AUX_PIN_CTRL, 32'h0100_0000);
    wr32(1'b0, CFG_OFS_AUX_PIN_CTRL, BE_ALL, 32'h2020_0000);
    settle(4);
    rd32(1'b0, CFG_OFS_AUX_PIN_CTRL, 32'h2021_0000);
    $display("test pins done");

    wr32(1'b0, CFG_OFS_AUX_PIN_CTRL, BE_ALL, 32'h8080_0000);
    wr32(1'b1, MEM_OFS_EVT_CLR, BE_ALL, 32'hffff_ffff);
    wr32(1'b1, MEM_OFS_MASK_SET, BE_ALL, 32'h0200_0000);
    ext_val = 2'b00;
    wait_irq(1'b1);
    rd32(1'b1, MEM_OFS_EVT_SET, 32'h0200_0000);
    rd32(1'b1, MEM_OFS_EVT_CLR, 32'h0200_0000);
    wr32(1'b1, MEM_OFS_EVT_CLR, BE_ALL, 32'h0200_0000);
    wait_irq(1'b0);
    ext_val = 2'b01;
    wait_irq(1'b1);
    wr32(1'b1, MEM_OFS_EVT_CLR, BE_ALL, 32'h0200_0000);
    wr32(1'b1, MEM_OFS_MASK_CLR, BE_ALL, 32'h0200_0000);
    ext_val = 2'b00;
    settle(8);
    chk({31'h0, irq_r}, 32'h0);
    rd32(1'b1, MEM_OFS_EVT_SET, 32'h0200_0000);
    rd32(1'b1, MEM_OFS_EVT_CLR, 32'h0);
    wr32(1'b1, MEM_OFS_EVT_CLR, BE_ALL, 32'h0200_0000);
    wr32(1'b0, CFG_OFS_AUX_PIN_CTRL, BE_ALL, 32'h0);
    ext_val = 2'b10;
    settle(8);
    rd32(1'b1, MEM_OFS_EVT_SET, 32'h0);
    $display("test events done");
    settle(3);
    summarize();
  end
endmodule // cfgaux_regs_tb
